// File: flash_ctrl_defs.svh
// Purpose: constants for the flash mode, command and die select logic
// Assumes: one 20 MHz clock, the host's burst clock sampled as a plain input
// Notes: commands arrive as decoded codes on a write strobe
`ifndef FLASH_CTRL_DEFS_SVH
`define FLASH_CTRL_DEFS_SVH
`define DATA_W        16
`define ADDR_W        25
`define BLK_W         9
`define NUM_BLOCKS    512
`define PARAM_KBYTE   32
`define MAIN_KBYTE    128
`define OTP_REGIONS   4
`define CMD_W         3
`define CMD_NONE      3'h0
`define CMD_PROGRAM   3'h1
`define CMD_ERASE     3'h2
`define CMD_SUSPEND   3'h3
`define CMD_RESUME    3'h4
`define CMD_LOCK      3'h5
`define CMD_UNLOCK    3'h6
`define CMD_CLR_STAT  3'h7
`define PROG_CYC      8'h0A
`define ERASE_CYC     8'h40
`define LAT_W         3
`define LAT_DEFAULT   3'h2
`define ST_READY      7
`define ST_ESUSP      6
`define ST_ERASE_ERR  5
`define ST_PROG_ERR   4
`define ST_VPP_ERR    3
`define ST_PSUSP      2
`define ST_LOCK_ERR   1
`endif

// File: flash_ctrl_pkg.sv
// Purpose: types shared by the flash control logic
// Assumes: flash_ctrl_defs.svh is included first
// Notes: none
`include "flash_ctrl_defs.svh"
package flash_ctrl_pkg;
  typedef enum logic [2:0] {
    WSM_IDLE, WSM_PROG, WSM_ERASE, WSM_PSUSP, WSM_ESUSP, WSM_EPROG,
    WSM_EPSUSP
  } wsm_state_t;
  typedef struct packed {
    logic               we;
    logic [`CMD_W-1:0]  code;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] data;
  } cmd_t;
  typedef struct packed {
    wsm_state_t         st;
    logic [7:0]         cnt;
    logic [7:0]         status;
    logic [`BLK_W-1:0]  ers_blk;
    logic [`BLK_W-1:0]  prg_blk;
    logic [`ADDR_W-1:0] prg_addr;
    logic [`NUM_BLOCKS-1:0] locked;
    logic               burst_mode;
    logic [`LAT_W-1:0]  latency;
    logic [`LAT_W-1:0]  lat_cnt;
    logic               in_burst;
    logic               prev_clk;
    logic               prev_adv;
    logic [`ADDR_W-1:0] burst_addr;
    logic [`DATA_W-1:0] dq;
    logic               wait_o;
    logic [1:0]         die_sel;
    logic [`BLK_W-1:0]  erased_blk;
    logic               erase_done;
  } flash_state_t;
endpackage : flash_ctrl_pkg

// File: flash_ctrl.sv
// Purpose: mode control, write state machine and die select of a NOR flash
// Assumes: all inputs synchronous to clk_in; array storage lives outside
// Notes: array data returns on array_data_in for the presented address
`timescale 1ns/1ps
`include "flash_ctrl_defs.svh"
module flash_ctrl (
  input  wire logic                   clk_in,
  input  wire logic                   reset_in,
  input  wire flash_ctrl_pkg::cmd_t   cmd_in,
  input  wire logic                   cfg_we_in,
  input  wire logic                   cfg_burst_in,
  input  wire logic [`LAT_W-1:0]      cfg_latency_in,
  input  wire logic                   chip_en_n_in,
  input  wire logic                   addr_valid_n_in,
  input  wire logic                   burst_clk_in,
  input  wire logic [`ADDR_W-1:0]     addr_in,
  input  wire logic [`DATA_W-1:0]     array_data_in,
  input  wire logic                   supply_low_in,
  input  wire logic [`OTP_REGIONS-1:0] otp_lock_in,
  output logic      [`DATA_W-1:0]     dq_out,
  output logic                        wait_out,
  output logic                        burst_mode_out,
  output logic      [7:0]             status_out,
  output logic      [1:0]             die_sel_out,
  output logic      [`BLK_W-1:0]      erased_blk_out,
  output logic                        erase_done_out
);
  flash_ctrl_pkg::flash_state_t s_q, s_d;
  logic              clk_rise;
  logic              adv_rise;
  logic [`BLK_W-1:0] cmd_blk;
  logic              cmd_prot;

  // Block number and protection of the command target; one OTP region
  // per top main block, so locking those needs no extra storage
  always_comb begin
    cmd_blk  = cmd_in.addr[`ADDR_W-1 -: `BLK_W];
    cmd_prot = s_q.locked[cmd_blk];
    for (int i = 0; i < `OTP_REGIONS; i++) begin
      if (otp_lock_in[i] && cmd_blk == `BLK_W'(`NUM_BLOCKS-1-i)) begin
        cmd_prot = 1'b1;
      end
    end
  end

  assign clk_rise = burst_clk_in & ~s_q.prev_clk;
  assign adv_rise = addr_valid_n_in & ~s_q.prev_adv;

  // Next-state logic for commands, the write state machine and reads
  always_comb begin
    s_d = s_q;
    s_d.prev_clk   = burst_clk_in;
    s_d.prev_adv   = addr_valid_n_in;
    s_d.erase_done = 1'b0;
    // Die select: top address bit chooses between the two halves
    if (chip_en_n_in) begin
      s_d.die_sel = 2'b00;
    end else if (addr_in[`ADDR_W-1]) begin
      s_d.die_sel = 2'b10;
    end else begin
      s_d.die_sel = 2'b01;
    end
    if (cfg_we_in) begin
      s_d.burst_mode = cfg_burst_in;
      s_d.latency    = cfg_latency_in;
    end
    // Algorithm countdown, no host action needed; frozen while suspended
    // so the remaining time is kept for the resume unless a program ran in an erase suspend
    if (s_q.cnt != 8'h00 &&
        (s_q.st == flash_ctrl_pkg::WSM_PROG ||
         s_q.st == flash_ctrl_pkg::WSM_EPROG ||
         s_q.st == flash_ctrl_pkg::WSM_ERASE)) begin
      s_d.cnt = s_q.cnt - 8'h01;
    end
    unique case (s_q.st)
      flash_ctrl_pkg::WSM_PROG, flash_ctrl_pkg::WSM_EPROG: begin
        if (supply_low_in) begin
          s_d.status[`ST_VPP_ERR]  = 1'b1;
          s_d.status[`ST_PROG_ERR] = 1'b1;
          s_d.cnt = 8'h00;
        end
        if (supply_low_in || s_q.cnt == 8'h01) begin
          s_d.st = (s_q.st == flash_ctrl_pkg::WSM_EPROG) ?
                   flash_ctrl_pkg::WSM_ESUSP : flash_ctrl_pkg::WSM_IDLE;
          s_d.status[`ST_READY] = 1'b1;
        end
      end
      flash_ctrl_pkg::WSM_ERASE: begin
        if (supply_low_in) begin
          s_d.status[`ST_VPP_ERR]   = 1'b1;
          s_d.status[`ST_ERASE_ERR] = 1'b1;
          s_d.cnt = 8'h00;
          s_d.st  = flash_ctrl_pkg::WSM_IDLE;
          s_d.status[`ST_READY] = 1'b1;
        end else if (s_q.cnt == 8'h01) begin
          s_d.erased_blk = s_q.ers_blk;
          s_d.erase_done = 1'b1;
          s_d.st = flash_ctrl_pkg::WSM_IDLE;
          s_d.status[`ST_READY] = 1'b1;
        end
      end
      default: ;
    endcase
    // Command interface: only path into the write state machine
    if (cmd_in.we) begin
      unique case (cmd_in.code)
        `CMD_PROGRAM, `CMD_ERASE: begin
          if (s_q.st == flash_ctrl_pkg::WSM_IDLE ||
              (s_q.st == flash_ctrl_pkg::WSM_ESUSP &&
               cmd_in.code == `CMD_PROGRAM &&
               cmd_blk != s_q.ers_blk)) begin
            s_d.status[`ST_READY] = 1'b1;
            if (supply_low_in) begin
              s_d.status[`ST_VPP_ERR] = 1'b1;
              s_d.status[cmd_in.code == `CMD_ERASE ?
                         `ST_ERASE_ERR : `ST_PROG_ERR] = 1'b1;
            end else if (cmd_prot) begin
              s_d.status[`ST_LOCK_ERR] = 1'b1;
              s_d.status[cmd_in.code == `CMD_ERASE ?
                         `ST_ERASE_ERR : `ST_PROG_ERR] = 1'b1;
            end else begin
              s_d.status[`ST_READY] = 1'b0;
              if (cmd_in.code == `CMD_ERASE) begin
                s_d.st      = flash_ctrl_pkg::WSM_ERASE;
                s_d.ers_blk = cmd_blk;
                s_d.cnt     = `ERASE_CYC;
              end else begin
                // One word per command: address taken whole, data not stored
                s_d.st = (s_q.st == flash_ctrl_pkg::WSM_ESUSP) ?
                         flash_ctrl_pkg::WSM_EPROG : flash_ctrl_pkg::WSM_PROG;
                s_d.prg_addr = cmd_in.addr;
                s_d.prg_blk  = cmd_blk;
                s_d.cnt      = `PROG_CYC;
              end
            end
          end
        end
        `CMD_SUSPEND: begin
          if (s_q.st == flash_ctrl_pkg::WSM_ERASE) begin
            s_d.st = flash_ctrl_pkg::WSM_ESUSP;
            s_d.status[`ST_ESUSP] = 1'b1;
            s_d.status[`ST_READY] = 1'b1;
          end else if (s_q.st == flash_ctrl_pkg::WSM_PROG) begin
            s_d.st = flash_ctrl_pkg::WSM_PSUSP;
            s_d.status[`ST_PSUSP] = 1'b1;
            s_d.status[`ST_READY] = 1'b1;
          end else if (s_q.st == flash_ctrl_pkg::WSM_EPROG) begin
            s_d.st = flash_ctrl_pkg::WSM_EPSUSP;
            s_d.status[`ST_PSUSP] = 1'b1;
            s_d.status[`ST_READY] = 1'b1;
          end
        end
        `CMD_RESUME: begin
          if (s_q.st == flash_ctrl_pkg::WSM_ESUSP) begin
            s_d.st = flash_ctrl_pkg::WSM_ERASE;
            // A program in the suspend reused the counter: the erase
            // restarts its timing, slower but never left unfinished
            if (s_q.cnt == 8'h00) begin
              s_d.cnt = `ERASE_CYC;
            end
            s_d.status[`ST_ESUSP] = 1'b0;
            s_d.status[`ST_READY] = 1'b0;
          end else if (s_q.st == flash_ctrl_pkg::WSM_PSUSP) begin
            s_d.st = flash_ctrl_pkg::WSM_PROG;
            s_d.status[`ST_PSUSP] = 1'b0;
            s_d.status[`ST_READY] = 1'b0;
          end else if (s_q.st == flash_ctrl_pkg::WSM_EPSUSP) begin
            s_d.st = flash_ctrl_pkg::WSM_EPROG;
            s_d.status[`ST_PSUSP] = 1'b0;
            s_d.status[`ST_READY] = 1'b0;
          end
        end
        `CMD_LOCK: s_d.locked[cmd_blk] = 1'b1;
        `CMD_UNLOCK: s_d.locked[cmd_blk] = 1'b0;
        `CMD_CLR_STAT: begin
          s_d.status[`ST_ERASE_ERR:`ST_VPP_ERR] = 3'b000;
          s_d.status[`ST_LOCK_ERR] = 1'b0;
        end
        default: ;
      endcase
    end
    // Read path; suspended targets are not served in WSM_PSUSP or WSM_ESUSP, others are
    if (chip_en_n_in) begin
      s_d.in_burst = 1'b0;
      s_d.wait_o   = 1'b0;
    end else if (!s_q.burst_mode) begin
      s_d.dq = array_data_in;
      s_d.wait_o = 1'b0;
    end else begin
      if (!s_q.in_burst && (adv_rise ||
          (!addr_valid_n_in && clk_rise))) begin
        s_d.burst_addr = addr_in;
        s_d.in_burst   = 1'b1;
        s_d.lat_cnt    = s_q.latency;
        s_d.wait_o     = 1'b1;
      end else if (s_q.in_burst && clk_rise) begin
        if (s_q.lat_cnt != `LAT_W'(0)) begin
          s_d.lat_cnt = s_q.lat_cnt - `LAT_W'(1);
        end else begin
          s_d.dq = array_data_in;
          s_d.wait_o = 1'b0;
          s_d.burst_addr = s_q.burst_addr + `ADDR_W'(1);
        end
      end
      if (!addr_valid_n_in && s_q.in_burst && clk_rise) begin
        s_d.in_burst = 1'b0; // New address restarts the burst
      end
    end
    // Reads of the word or block under suspended work are held off in WSM_PSUSP and WSM_ESUSP only
    if ((s_q.st == flash_ctrl_pkg::WSM_PSUSP &&
         addr_in == s_q.prg_addr) ||
        (s_q.st == flash_ctrl_pkg::WSM_ESUSP &&
         addr_in[`ADDR_W-1 -: `BLK_W] == s_q.ers_blk)) begin
      s_d.dq = `DATA_W'(0);
    end
  end

  // Single state register; reset gives async page read and ready status
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      s_q <= '0;
      s_q.status[`ST_READY] <= 1'b1;
      s_q.latency <= `LAT_DEFAULT;
      s_q.prev_adv <= 1'b1;
      s_q.st <= flash_ctrl_pkg::WSM_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign dq_out         = s_q.dq;
  assign wait_out       = s_q.wait_o;
  assign burst_mode_out = s_q.burst_mode;
  assign status_out     = s_q.status;
  assign die_sel_out    = s_q.die_sel;
  assign erased_blk_out = s_q.erased_blk;
  assign erase_done_out = s_q.erase_done;

  // Burst mode changes only through a configuration write
  chk_burst_cfg: assert property (@(posedge clk_in) disable iff (reset_in)
    !$past(cfg_we_in) |-> burst_mode_out == $past(burst_mode_out))
    else $error("burst mode changed without config write");
  chk_die_upper: assert property (@(posedge clk_in) disable iff (reset_in)
    (!chip_en_n_in && addr_in[`ADDR_W-1]) |=> die_sel_out == 2'b10)
    else $error("upper die not selected");
  chk_die_lower: assert property (@(posedge clk_in) disable iff (reset_in)
    (!chip_en_n_in && !addr_in[`ADDR_W-1]) |=> die_sel_out == 2'b01)
    else $error("lower die not selected");
  chk_die_single: assert property (@(posedge clk_in) disable iff (reset_in)
    die_sel_out != 2'b11)
    else $error("both dies selected");
  chk_vpp_block: assert property (@(posedge clk_in) disable iff (reset_in)
    (supply_low_in && cmd_in.we && cmd_in.code == `CMD_ERASE &&
     s_q.st == flash_ctrl_pkg::WSM_IDLE) |=>
     s_q.st == flash_ctrl_pkg::WSM_IDLE && status_out[`ST_VPP_ERR])
    else $error("erase started at low supply");
  chk_erase_done: assert property (@(posedge clk_in) disable iff (reset_in)
    $rose(erase_done_out) |-> status_out[`ST_READY] &&
     erased_blk_out == $past(s_q.ers_blk))
    else $error("erase finished on wrong block");
  chk_lock_reject: assert property (@(posedge clk_in) disable iff (reset_in)
    (cmd_in.we && cmd_in.code == `CMD_PROGRAM && cmd_prot &&
     !supply_low_in && s_q.st == flash_ctrl_pkg::WSM_IDLE) |=>
     status_out[`ST_LOCK_ERR])
    else $error("program into locked block");
  chk_prog_time: assert property (@(posedge clk_in) disable iff (reset_in)
    (s_q.st == flash_ctrl_pkg::WSM_IDLE && s_d.st == flash_ctrl_pkg::WSM_PROG)
     |=> (!status_out[`ST_READY] || status_out[`ST_PSUSP] ||
          status_out[`ST_VPP_ERR]) [*8])
    else $error("program ended early");
  chk_async_nowait: assert property (@(posedge clk_in) disable iff (reset_in)
    !burst_mode_out |=> !wait_out)
    else $error("wait in asynchronous mode");
endmodule : flash_ctrl

// File: flash_host_model.sv
// Purpose: host side of the burst read interface
// Assumes: driven off the falling edge of the system clock
// Notes: the burst clock stands still outside a frame
`timescale 1ns/1ps
module flash_host_model (
  input  wire logic clk_in,
  input  wire logic reset_in,
  input  wire logic run_in,
  input  wire logic wait_in,
  output logic      burst_clk_out,
  output logic      addr_valid_n_out,
  output int        wait_seen_out
);
  logic [5:0] cnt_q;
  // Frame: valid low two cycles, then the clock toggles every two cycles
  always_ff @(negedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_q            <= 6'h00;
      burst_clk_out    <= 1'b0;
      addr_valid_n_out <= 1'b1;
      wait_seen_out    <= 0;
    end else begin
      if (run_in && cnt_q == 6'h00) begin
        cnt_q <= 6'h01;
        wait_seen_out <= 0;
      end else if (cnt_q != 6'h00) begin
        cnt_q <= cnt_q + 6'h01;
      end
      // Address caught at the valid rise or the first clock edge
      addr_valid_n_out <= !(cnt_q == 6'h00 && run_in || cnt_q == 6'h01);
      burst_clk_out    <= (cnt_q >= 6'h03) && cnt_q[1];
      // No data taken here at all; cycles with wait high inside a frame are counted
      if (cnt_q != 6'h00 && wait_in) begin
        wait_seen_out <= wait_seen_out + 1;
      end
    end
  end
endmodule : flash_host_model

// File: nor_flash_mode_and_die_select_test.sv
// Purpose: self-checking bench of the flash mode and die select block
// Assumes: inputs change on the falling clock edge
// Notes: block numbers are compared relative, not absolute
`timescale 1ns/1ps
`include "flash_ctrl_defs.svh"
module nor_flash_mode_and_die_select_test;
  logic                   clk, rst, cfg_we, cfg_burst, ce_n, low, run;
  logic [`LAT_W-1:0]      cfg_lat;
  logic [`ADDR_W-1:0]     addr;
  logic [`DATA_W-1:0]     arr, dq;
  logic [`OTP_REGIONS-1:0] otp;
  logic                   bclk, adv_n, wt, bmode, edone;
  logic [7:0]             st;
  logic [1:0]             die;
  logic [`BLK_W-1:0]      eblk, b0;
  flash_ctrl_pkg::cmd_t   cmd;
  int                     fail_count, n_compared, cycles, n, ws;
  flash_ctrl dut (.clk_in(clk), .reset_in(rst), .cmd_in(cmd),
    .cfg_we_in(cfg_we), .cfg_burst_in(cfg_burst), .cfg_latency_in(cfg_lat),
    .chip_en_n_in(ce_n), .addr_valid_n_in(adv_n), .burst_clk_in(bclk),
    .addr_in(addr), .array_data_in(arr), .supply_low_in(low),
    .otp_lock_in(otp), .dq_out(dq), .wait_out(wt), .burst_mode_out(bmode),
    .status_out(st), .die_sel_out(die), .erased_blk_out(eblk),
    .erase_done_out(edone));
  flash_host_model host (.clk_in(clk), .reset_in(rst), .run_in(run),
    .wait_in(wt), .burst_clk_out(bclk), .addr_valid_n_out(adv_n),
    .wait_seen_out(ws));
  // Clock of 50 ns
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Hang guard; the longest scenario is a few hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end
  task automatic check(input logic [15:0] seen, exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic results();
    $display("fail_count=%0d n_compared=%0d", fail_count, n_compared);
    if (fail_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  task automatic cycle(input int k);
    repeat (k) @(negedge clk);
  endtask : cycle
  // One command; strobe high for exactly one edge
  task automatic issue(input logic [2:0] c, input logic [24:0] a);
    @(negedge clk);
    cmd = '{we: 1'b1, code: c, addr: a, data: 16'hBEEF};
    @(negedge clk);
    cmd.we = 1'b0;
  endtask : issue
  task automatic wait_rdy();
    n = 0;
    cycle(1);
    check(st[`ST_READY], 1'b0, "ready not low when busy");
    while (st[`ST_READY] !== 1'b1 && n < 300) begin
      cycle(1);
      n++;
    end
    check(16'(n < 300), 16'h0001, "operation never ends");
  endtask : wait_rdy
  task automatic wait_done();
    n = 0;
    while (edone !== 1'b1 && n < 300) begin
      cycle(1);
      n++;
    end
    check(16'(n < 300), 16'h0001, "erase never ends");
  endtask : wait_done
  task automatic t_reset();
    check(st, 16'h0080, "status after reset");
    check({bmode, wt, die}, 16'h0000, "outputs after reset");
  endtask : t_reset
  task automatic t_program();
    issue(`CMD_PROGRAM, 25'h010_0004);
    wait_rdy();
    check(16'(n >= 5), 16'h0001, "program ended early");
    check(st[`ST_PROG_ERR], 1'b0, "spurious program error");
  endtask : t_program
  // Two words of one block, then the next block up
  task automatic t_erase();
    logic [24:0] a[3] = '{25'h020_0000, 25'h020_0001, 25'h021_0000};
    for (int i = 0; i < 3; i++) begin
      issue(`CMD_ERASE, a[i]);
      wait_done();
      check(16'(n >= 40), 16'h0001, "erase ended early");
      if (i == 0) b0 = eblk;
      check(eblk, b0 + 9'(i / 2), "wrong erased block");
      cycle(2);
      check(st[`ST_READY], 1'b1, "ready after erase");
    end
  endtask : t_erase
  task automatic t_lockout();
    low = 1'b1;
    issue(`CMD_PROGRAM, 25'h010_0000);
    issue(`CMD_ERASE, 25'h010_0000);
    cycle(2);
    check(st[`ST_VPP_ERR], 1'b1, "no supply error");
    check(st[`ST_READY], 1'b1, "busy despite lockout");
    low = 1'b0;
    issue(`CMD_CLR_STAT, 25'h000_0000);
    cycle(2);
    check(st, 16'h0080, "status not cleared");
  endtask : t_lockout
  // Lock refuses at once; the neighbour block still programs
  task automatic t_lock();
    issue(`CMD_LOCK, 25'h030_0000);
    issue(`CMD_PROGRAM, 25'h030_0000);
    cycle(2);
    check(st[`ST_LOCK_ERR], 1'b1, "locked block programmed");
    issue(`CMD_CLR_STAT, 25'h000_0000);
    issue(`CMD_PROGRAM, 25'h031_0000);
    wait_rdy();
    issue(`CMD_UNLOCK, 25'h030_0000);
    issue(`CMD_PROGRAM, 25'h030_0000);
    wait_rdy();
    for (int i = 0; i < 4; i++) begin
      otp = 4'h1 << i;
      issue(`CMD_PROGRAM, 25'h1FF_0000 - 25'(i) * 25'h001_0000);
      cycle(2);
      check(st[`ST_LOCK_ERR], 1'b1, "OTP region programmed");
      issue(`CMD_CLR_STAT, 25'h000_0000);
    end
    otp = 4'h0;
  endtask : t_lock
  // Suspend, program elsewhere during erase suspend, then resume
  task automatic t_susp(input logic erase, input int bit_no);
    issue(erase ? `CMD_ERASE : `CMD_PROGRAM, 25'h040_0000);
    issue(`CMD_SUSPEND, 25'h040_0000);
    cycle(3);
    check(st[bit_no], 1'b1, "suspend not shown");
    if (erase) begin
      issue(`CMD_PROGRAM, 25'h050_0000);
      wait_rdy();
    end
    issue(`CMD_RESUME, 25'h040_0000);
    cycle(3);
    check(st[bit_no], 1'b0, "resume not shown");
    if (erase) wait_done();
    else wait_rdy();
  endtask : t_susp
  task automatic t_die();
    for (int s = 0; s < 2; s++) begin
      ce_n = 1'b0;
      addr = {1'(s), 24'h00_0100};
      cycle(2);
      check(die, {s[0], !s[0]}, "wrong die");
    end
    ce_n = 1'b1;
    cycle(2);
    check(die, 2'b00, "die kept when deselected");
  endtask : t_die
  task automatic t_burst(input logic on);
    ce_n = 1'b0;
    addr = 25'h000_0100;
    @(negedge clk);
    run = 1'b1;
    @(negedge clk);
    run = 1'b0;
    cycle(60);
    check(16'(ws > 0), 16'(on), "wait output wrong");
    if (on) check(dq, 16'hC3A5, "burst data");
    ce_n = 1'b1;
  endtask : t_burst
  initial begin
    rst = 1'b1;
    cmd = '0;
    {cfg_we, cfg_burst, low, run} = 4'h0;
    cfg_lat = `LAT_DEFAULT;
    ce_n = 1'b1;
    addr = 25'h000_0000;
    arr = 16'hC3A5;
    otp = 4'h0;
    cycle(2);
    rst = 1'b0;
    t_reset();
    t_program();
    t_erase();
    t_lockout();
    t_lock();
    t_susp(1'b1, `ST_ESUSP);
    t_susp(1'b0, `ST_PSUSP);
    t_die();
    t_burst(1'b0);
    @(negedge clk);
    {cfg_we, cfg_burst} = 2'b11;
    @(negedge clk);
    cfg_we = 1'b0;
    cycle(1);
    check(bmode, 1'b1, "burst mode not set");
    t_burst(1'b1);
    results();
  end
endmodule : nor_flash_mode_and_die_select_test
